// >>> hrd_defs.svh
`ifndef HRD_DEFS_SVH
`define HRD_DEFS_SVH

// Byte offsets (bearer bank 0x00..0x73, signalling bank 0x80..0xBA)
`define HRD_B_LO               8'h00
`define HRD_B_HI               8'h73
`define HRD_D_LO               8'h80
`define HRD_D_HI               8'hBA
`define HRD_OFF_B_IRQ_STATUS   8'h20
`define HRD_OFF_B_IRQ_MASK     8'h24
`define HRD_OFF_B_STATUS       8'h28
`define HRD_OFF_B_COMMAND      8'h2C
`define HRD_OFF_B_MODE         8'h30
`define HRD_OFF_B_EXT_IRQ      8'h34
`define HRD_OFF_B_CTRL_ONE     8'h38
`define HRD_OFF_B_CTRL_TWO     8'h3C
`define HRD_OFF_B_TX_CNT_HI    8'h40
`define HRD_OFF_B_RX_CNT_HI    8'h44
`define HRD_OFF_B_TX_SLOT      8'h48
`define HRD_OFF_B_RX_SLOT      8'h4C
`define HRD_OFF_D_IRQ_STATUS   8'h80
`define HRD_OFF_D_IRQ_MASK     8'h84
`define HRD_OFF_D_EXT_IRQ      8'h88
`define HRD_OFF_D_STATUS       8'h8C
`define HRD_OFF_D_COMMAND      8'h90
`define HRD_OFF_D_MODE         8'h94
`define HRD_OFF_D_RX_CNT_LO    8'h98
`define HRD_OFF_D_RX_CNT_HI    8'h9C
`define HRD_OFF_SERIAL_CTRL    8'hA0
`define HRD_OFF_CI_RECEIVE     8'hA4
`define HRD_OFF_CI_TRANSMIT    8'hA8
`define HRD_OFF_SYNC_CTRL      8'hAC
`define HRD_OFF_FILL_CFG       8'hB0

// Reset values
`define HRD_RST_ZERO           8'h00
`define HRD_RST_STATUS         8'h48
`define HRD_RST_CI_RECEIVE     8'h7C
`define HRD_RST_CI_TRANSMIT    8'h3F
`define HRD_RST_CNT_HI_LOW5    5'h00

// Field positions
`define HRD_CTRL_ONE_PWR_UP    6
`define HRD_SERIAL_DRIVE_LOW   7
`define HRD_STATUS_CMD_BUSY    2
`define HRD_CMD_RESET_RX       6
`define HRD_CMD_BUSY_CYCLES    4'h3

`endif

// >>> hrd_pkg.sv
package hrd_pkg;
   typedef enum logic [1:0] {
      HRD_IDLE    = 2'b00,
      HRD_ACTIVE  = 2'b01
   } hrd_state_type;
endpackage : hrd_pkg

// >>> hrd_regs.sv
`include "hrd_defs.svh"

// Operation
// - Reset puts device idle, registers at defaults
// - Bearer registers decode 00h through 73h
// - Signalling registers decode 80h through BAh
// - Bearer control one resets to 00
// - Bearer control two resets to 00
// - Bearer mode register resets to 00
// - Bearer status reads 48 after reset
// - Bearer interrupt status, mask, extended reset 00
// - Bearer byte count high registers reset 00
// - Signalling status reads 48 after reset
// - Signalling count low 00, high low5 clear
// - Serial control resets 00, upstream line high
// - Command/indicate receive resets to 7C
// - Command/indicate transmit resets to 3F
// - Synchronous transfer control resets to 00
// - Frame fill config resets to 00
module hrd_regs (
   input  wire logic        CLOCK,
   input  wire logic        RESET_N,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic [7:0]  B_EVENT,
   input  wire logic [7:0]  D_EVENT,
   input  wire logic [7:0]  CI_RX_CODE,
   input  wire logic        CI_RX_LOAD,
   output logic             IRQ,
   output logic             UPSTREAM_LINE_O,
   output logic             UPSTREAM_LINE_OE,
   output logic             POWERED_UP,
   output logic [7:0]       CI_TX_CODE
);

   logic                  ph_valid;
   logic                  ph_write;
   logic [7:0]            ph_addr;
   logic                  rd_go;
   logic                  wr_go;
   logic [7:0]            rd_mux;
   logic                  hit_any;
   logic [7:0]            b_ctrl_one;
   logic [7:0]            b_ctrl_two;
   logic [7:0]            b_mode;
   logic [7:0]            b_irq_status;
   logic [7:0]            b_irq_mask;
   logic [7:0]            b_ext_irq;
   logic [7:0]            b_tx_cnt_hi;
   logic [7:0]            b_rx_cnt_hi;
   logic [7:0]            b_tx_slot;
   logic [7:0]            b_rx_slot;
   logic [7:0]            d_irq_status;
   logic [7:0]            d_irq_mask;
   logic [7:0]            d_ext_irq;
   logic [7:0]            d_mode;
   logic [7:0]            d_rx_cnt_lo;
   logic [4:0]            d_rx_cnt_hi;
   logic [7:0]            serial_ctrl;
   logic [7:0]            ci_receive;
   logic [7:0]            ci_transmit;
   logic [7:0]            sync_ctrl;
   logic [7:0]            fill_cfg;
   logic [3:0]            b_busy_cnt;
   logic [3:0]            d_busy_cnt;
   hrd_pkg::hrd_state_type state;
   hrd_pkg::hrd_state_type next_state;

   // Address phase capture; slave always ready, so data phase is one cycle
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_addr  <= 8'h00;
      end else if (HREADY) begin
         ph_valid <= HSEL & HTRANS[1];
         ph_write <= HWRITE;
         ph_addr  <= HADDR[7:0];
      end
   end

   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;
   assign wr_go     = ph_valid & ph_write;
   assign rd_go     = ph_valid & ~ph_write;

   // Banks decode only inside their windows; gaps read zero
   assign hit_any = (ph_addr <= `HRD_B_HI) ||
                    (ph_addr >= `HRD_D_LO && ph_addr <= `HRD_D_HI);

   always_comb begin
      rd_mux = 8'h00;
      if (hit_any) begin
         case (ph_addr)
            `HRD_OFF_B_IRQ_STATUS: rd_mux = b_irq_status;
            `HRD_OFF_B_IRQ_MASK:   rd_mux = b_irq_mask;
            `HRD_OFF_B_STATUS:     rd_mux = `HRD_RST_STATUS |
                                            {5'h00, (b_busy_cnt != 4'h0), 2'h0};
            `HRD_OFF_B_MODE:       rd_mux = b_mode;
            `HRD_OFF_B_EXT_IRQ:    rd_mux = b_ext_irq;
            `HRD_OFF_B_CTRL_ONE:   rd_mux = b_ctrl_one;
            `HRD_OFF_B_CTRL_TWO:   rd_mux = b_ctrl_two;
            `HRD_OFF_B_TX_CNT_HI:  rd_mux = b_tx_cnt_hi;
            `HRD_OFF_B_RX_CNT_HI:  rd_mux = b_rx_cnt_hi;
            `HRD_OFF_B_TX_SLOT:    rd_mux = b_tx_slot;
            `HRD_OFF_B_RX_SLOT:    rd_mux = b_rx_slot;
            `HRD_OFF_D_IRQ_STATUS: rd_mux = d_irq_status;
            `HRD_OFF_D_IRQ_MASK:   rd_mux = d_irq_mask;
            `HRD_OFF_D_EXT_IRQ:    rd_mux = d_ext_irq;
            `HRD_OFF_D_STATUS:     rd_mux = `HRD_RST_STATUS |
                                            {5'h00, (d_busy_cnt != 4'h0), 2'h0};
            `HRD_OFF_D_MODE:       rd_mux = d_mode;
            `HRD_OFF_D_RX_CNT_LO:  rd_mux = d_rx_cnt_lo;
            `HRD_OFF_D_RX_CNT_HI:  rd_mux = {3'h0, d_rx_cnt_hi};
            `HRD_OFF_SERIAL_CTRL:  rd_mux = serial_ctrl;
            `HRD_OFF_CI_RECEIVE:   rd_mux = ci_receive;
            `HRD_OFF_CI_TRANSMIT:  rd_mux = ci_transmit;
            `HRD_OFF_SYNC_CTRL:    rd_mux = sync_ctrl;
            `HRD_OFF_FILL_CFG:     rd_mux = fill_cfg;
            default:               rd_mux = 8'h00;
         endcase
      end
   end

   // Read data decoded combinationally from the captured address, ready in the data phase
   always_comb begin
      HRDATA = {24'h00_0000, rd_mux};
   end

   // Writable configuration registers
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         b_ctrl_one  <= `HRD_RST_ZERO;
         b_ctrl_two  <= `HRD_RST_ZERO;
         b_mode      <= `HRD_RST_ZERO;
         b_irq_mask  <= `HRD_RST_ZERO;
         b_tx_cnt_hi <= `HRD_RST_ZERO;
         b_tx_slot   <= `HRD_RST_ZERO;
         b_rx_slot   <= `HRD_RST_ZERO;
         d_irq_mask  <= `HRD_RST_ZERO;
         d_mode      <= `HRD_RST_ZERO;
         serial_ctrl <= `HRD_RST_ZERO;
         ci_transmit <= `HRD_RST_CI_TRANSMIT;
         sync_ctrl   <= `HRD_RST_ZERO;
         fill_cfg    <= `HRD_RST_ZERO;
      end else if (wr_go) begin
         case (ph_addr)
            `HRD_OFF_B_CTRL_ONE:  b_ctrl_one  <= HWDATA[7:0];
            `HRD_OFF_B_CTRL_TWO:  b_ctrl_two  <= HWDATA[7:0];
            `HRD_OFF_B_MODE:      b_mode      <= HWDATA[7:0];
            `HRD_OFF_B_IRQ_MASK:  b_irq_mask  <= HWDATA[7:0];
            `HRD_OFF_B_TX_CNT_HI: b_tx_cnt_hi <= HWDATA[7:0];
            `HRD_OFF_B_TX_SLOT:   b_tx_slot   <= HWDATA[7:0];
            `HRD_OFF_B_RX_SLOT:   b_rx_slot   <= HWDATA[7:0];
            `HRD_OFF_D_IRQ_MASK:  d_irq_mask  <= HWDATA[7:0];
            `HRD_OFF_D_MODE:      d_mode      <= HWDATA[7:0];
            `HRD_OFF_SERIAL_CTRL: serial_ctrl <= HWDATA[7:0];
            `HRD_OFF_CI_TRANSMIT: ci_transmit <= HWDATA[7:0];
            `HRD_OFF_SYNC_CTRL:   sync_ctrl   <= HWDATA[7:0];
            `HRD_OFF_FILL_CFG:    fill_cfg    <= HWDATA[7:0];
            default:              ;
         endcase
      end
   end

   // Sticky event bits; an event in the clearing read cycle survives
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         b_irq_status <= `HRD_RST_ZERO;
         b_ext_irq    <= `HRD_RST_ZERO;
         d_irq_status <= `HRD_RST_ZERO;
         d_ext_irq    <= `HRD_RST_ZERO;
      end else begin
         b_irq_status <= ((rd_go && ph_addr == `HRD_OFF_B_IRQ_STATUS) ? 8'h00 : b_irq_status)
                         | B_EVENT;
         d_irq_status <= ((rd_go && ph_addr == `HRD_OFF_D_IRQ_STATUS) ? 8'h00 : d_irq_status)
                         | D_EVENT;
         b_ext_irq    <= (rd_go && ph_addr == `HRD_OFF_B_EXT_IRQ) ? 8'h00 : b_ext_irq;
         d_ext_irq    <= ((rd_go && ph_addr == `HRD_OFF_D_EXT_IRQ) ? 8'h00 : d_ext_irq)
                         | {7'h00, CI_RX_LOAD & (CI_RX_CODE[5:2] != ci_receive[5:2])};
      end
   end

   // Command writes hold the busy flag for a few cycles; reset-receive clears counts
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         b_busy_cnt  <= 4'h0;
         d_busy_cnt  <= 4'h0;
         b_rx_cnt_hi <= `HRD_RST_ZERO;
         d_rx_cnt_lo <= `HRD_RST_ZERO;
         d_rx_cnt_hi <= `HRD_RST_CNT_HI_LOW5;
      end else begin
         if (wr_go && ph_addr == `HRD_OFF_B_COMMAND) begin
            b_busy_cnt <= `HRD_CMD_BUSY_CYCLES;
            if (HWDATA[`HRD_CMD_RESET_RX]) begin
               b_rx_cnt_hi <= `HRD_RST_ZERO;
            end
         end else if (b_busy_cnt != 4'h0) begin
            b_busy_cnt <= b_busy_cnt - 4'h1;
         end
         if (wr_go && ph_addr == `HRD_OFF_D_COMMAND) begin
            d_busy_cnt <= `HRD_CMD_BUSY_CYCLES;
            if (HWDATA[`HRD_CMD_RESET_RX]) begin
               d_rx_cnt_lo <= `HRD_RST_ZERO;
               d_rx_cnt_hi <= `HRD_RST_CNT_HI_LOW5;
            end
         end else if (d_busy_cnt != 4'h0) begin
            d_busy_cnt <= d_busy_cnt - 4'h1;
         end
      end
   end

   // Received command/indicate code latched on a load strobe
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         ci_receive <= `HRD_RST_CI_RECEIVE;
      end else if (CI_RX_LOAD) begin
         ci_receive <= CI_RX_CODE;
      end
   end

   // Idle until software powers up the bearer channel
   always_comb begin
      case (state)
         hrd_pkg::HRD_IDLE:   next_state = b_ctrl_one[`HRD_CTRL_ONE_PWR_UP] ?
                                           hrd_pkg::HRD_ACTIVE : hrd_pkg::HRD_IDLE;
         hrd_pkg::HRD_ACTIVE: next_state = b_ctrl_one[`HRD_CTRL_ONE_PWR_UP] ?
                                           hrd_pkg::HRD_ACTIVE : hrd_pkg::HRD_IDLE;
         default:             next_state = hrd_pkg::HRD_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         state <= hrd_pkg::HRD_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Open-drain upstream line: released (high) unless software pulls it low
   assign UPSTREAM_LINE_O  = 1'b0;
   assign UPSTREAM_LINE_OE = serial_ctrl[`HRD_SERIAL_DRIVE_LOW];
   assign POWERED_UP       = (state == hrd_pkg::HRD_ACTIVE);
   assign CI_TX_CODE       = ci_transmit;
   assign IRQ = |(b_irq_status & ~b_irq_mask) | |(d_irq_status & ~d_irq_mask) |
                |b_ext_irq | |(d_ext_irq & ~d_irq_mask);

endmodule : hrd_regs

// >>> hrd_host.sv
module hrd_host (
   input  wire logic        clock,
   input  wire logic [31:0] hrdata,
   input  wire logic        hready,
   output logic             hsel,
   output logic      [31:0] haddr,
   output logic      [1:0]  htrans,
   output logic             hwrite,
   output logic      [2:0]  hsize,
   output logic      [31:0] hwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
   end
   // Single word transfer; no wait-state count is assumed
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      do @(posedge clock); while (hready !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      // A read drives the complement of the previous bus data, so a second read restores it
      hwdata <= w ? d : ~hwdata;
      do @(posedge clock); while (hready !== 1'b1);
      q = hrdata;
   endtask : xfer
endmodule : hrd_host

// >>> hrd_regs_props.sv
module hrd_regs_props (
   input wire logic        CLOCK,
   input wire logic        RESET_N,
   input wire logic        HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0]  HTRANS,
   input wire logic        HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic        HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic        HREADYOUT,
   input wire logic        HRESP,
   input wire logic        IRQ,
   input wire logic        UPSTREAM_LINE_O,
   input wire logic        UPSTREAM_LINE_OE,
   input wire logic        POWERED_UP,
   input wire logic [7:0]  CI_TX_CODE
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);
   logic       rd_ph;
   logic       wr_ph;
   logic [7:0] ph_addr;
   logic       gap;
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         rd_ph <= 1'b0;
         wr_ph <= 1'b0;
         ph_addr <= 8'h00;
      end else if (HREADY) begin
         rd_ph <= HSEL && HTRANS[1] && !HWRITE;
         wr_ph <= HSEL && HTRANS[1] && HWRITE;
         ph_addr <= HADDR[7:0];
      end
   end
   assign gap = (ph_addr > 8'h73 && ph_addr < 8'h80) || ph_addr > 8'hBA;
   property p_ready; HREADYOUT && !HRESP; endproperty
   a_ready: assert property (p_ready) else $error("slave not ready or not okay");
   property p_gap; rd_ph && gap |-> HRDATA == 32'h0000_0000; endproperty
   a_gap: assert property (p_gap) else $error("address outside banks read nonzero");
   property p_upper; rd_ph |-> HRDATA[31:8] == 24'h00_0000; endproperty
   a_upper: assert property (p_upper) else $error("read data upper bits nonzero");
   property p_rst_irq; $rose(RESET_N) |-> !IRQ; endproperty
   a_rst_irq: assert property (p_rst_irq) else $error("interrupt pending after reset");
   property p_rst_ci; $rose(RESET_N) |-> CI_TX_CODE == 8'h3F; endproperty
   a_rst_ci: assert property (p_rst_ci) else $error("transmit code wrong after reset");
   property p_rst_line; $rose(RESET_N) |-> !UPSTREAM_LINE_OE && !POWERED_UP; endproperty
   a_rst_line: assert property (p_rst_line) else $error("line or power wrong after reset");
   property p_serial; wr_ph && ph_addr == 8'hA0 |=> UPSTREAM_LINE_OE == $past(HWDATA[7]) && !UPSTREAM_LINE_O; endproperty
   a_serial: assert property (p_serial) else $error("line enable does not follow write");
   property p_power; wr_ph && ph_addr == 8'h38 |=> ##1 POWERED_UP == $past(HWDATA[6], 2); endproperty
   a_power: assert property (p_power) else $error("power state does not follow write");
   property p_ci_wr; wr_ph && ph_addr == 8'hA8 |=> CI_TX_CODE == $past(HWDATA[7:0]); endproperty
   a_ci_wr: assert property (p_ci_wr) else $error("transmit code does not follow write");
endmodule : hrd_regs_props
bind hrd_regs hrd_regs_props hrd_regs_props_inst (.CLOCK(CLOCK), .RESET_N(RESET_N), .HSEL(HSEL),
   .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
   .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ),
   .UPSTREAM_LINE_O(UPSTREAM_LINE_O), .UPSTREAM_LINE_OE(UPSTREAM_LINE_OE),
   .POWERED_UP(POWERED_UP), .CI_TX_CODE(CI_TX_CODE));

// >>> tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] b_event = 8'h00;
   logic [7:0] d_event = 8'h00;
   logic [7:0] ci_rx_code = 8'h00;
   logic ci_rx_load = 1'b0;
   logic hsel, hwrite, hready, hresp, irq, up_o, up_oe, powered_up;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] ci_tx_code, v;
   logic [7:0] rw [13] = '{8'h24, 8'h30, 8'h38, 8'h3C, 8'h40, 8'h48, 8'h4C, 8'h84, 8'h94,
                           8'hA0, 8'hA8, 8'hAC, 8'hB0};
   int fail_count = 0;
   int checks_done = 0;
   int cycles = 0;
   // Pulled-up line: high whenever the device does not drive it
   wire upstream_line = up_oe ? up_o : 1'b1;
   hrd_host hrd_host_inst (.clock(clock), .hrdata(hrdata), .hready(hready), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   hrd_regs hrd_regs_inst (.CLOCK(clock), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .B_EVENT(b_event),
      .D_EVENT(d_event), .CI_RX_CODE(ci_rx_code), .CI_RX_LOAD(ci_rx_load), .IRQ(irq),
      .UPSTREAM_LINE_O(up_o), .UPSTREAM_LINE_OE(up_oe), .POWERED_UP(powered_up),
      .CI_TX_CODE(ci_tx_code));
   always #5 clock = ~clock;
   task conclude;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         conclude();
      end
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check
   function logic [31:0] reset_of(input logic [7:0] a);
      case (a)
         8'h28, 8'h8C: reset_of = 32'h0000_0048;
         8'hA4: reset_of = 32'h0000_007C;
         8'hA8: reset_of = 32'h0000_003F;
         default: reset_of = 32'h0000_0000;
      endcase
   endfunction : reset_of
   task do_reset;
      @(posedge clock);
      reset_n <= 1'b0;
      repeat (16) @(posedge clock);
      reset_n <= 1'b1;
   endtask : do_reset
   // Commands are write-only, so their read value is left open
   task scan;
      for (int a = 0; a < 192; a += 4) begin
         if (a != 8'h2C && a != 8'h90) begin
            hrd_host_inst.xfer(1'b0, a[7:0], 32'h0, q);
            check(q, reset_of(a[7:0]));
         end
      end
      check({31'h0, upstream_line}, 32'h1);
      check({24'h0, ci_tx_code}, 32'h3F);
   endtask : scan
   task pulse(input logic [7:0] b, input logic [7:0] d);
      @(posedge clock);
      b_event <= b;
      d_event <= d;
      @(posedge clock);
      b_event <= 8'h00;
      d_event <= 8'h00;
      @(posedge clock);
      #1;
   endtask : pulse
   initial begin
      void'($urandom(5));
      do_reset();
      scan();
      foreach (rw[i]) begin
         v = 8'($urandom);
         hrd_host_inst.xfer(1'b1, rw[i], {24'h0, v}, q);
         hrd_host_inst.xfer(1'b0, rw[i], 32'h0, q);
         check(q, {24'h0, v});
      end
      hrd_host_inst.xfer(1'b1, 8'h28, 32'hFF, q);
      hrd_host_inst.xfer(1'b0, 8'h28, 32'h0, q);
      check(q, 32'h48);
      // A command write shows busy in status while the next read lands
      hrd_host_inst.xfer(1'b1, 8'h2C, 32'h40, q);
      hrd_host_inst.xfer(1'b0, 8'h28, 32'h0, q);
      check(q, 32'h4C);
      hrd_host_inst.xfer(1'b1, 8'hA0, 32'h80, q);
      @(posedge clock);
      #1;
      check({31'h0, upstream_line}, 32'h0);
      hrd_host_inst.xfer(1'b1, 8'h38, 32'h40, q);
      repeat (2) @(posedge clock);
      #1;
      check({31'h0, powered_up}, 32'h1);
      hrd_host_inst.xfer(1'b1, 8'h24, 32'h0, q);
      hrd_host_inst.xfer(1'b1, 8'h84, 32'hFF, q);
      v = 8'($urandom) | 8'h01;
      pulse(v, v);
      check({31'h0, irq}, 32'h1);
      hrd_host_inst.xfer(1'b0, 8'h20, 32'h0, q);
      check(q, {24'h0, v});
      hrd_host_inst.xfer(1'b0, 8'h20, 32'h0, q);
      check(q, 32'h0);
      #1;
      check({31'h0, irq}, 32'h0);
      hrd_host_inst.xfer(1'b0, 8'h80, 32'h0, q);
      check(q, {24'h0, v});
      @(posedge clock);
      ci_rx_code <= 8'($urandom) & 8'hC3;
      ci_rx_load <= 1'b1;
      @(posedge clock);
      ci_rx_load <= 1'b0;
      hrd_host_inst.xfer(1'b0, 8'hA4, 32'h0, q);
      check(q, {24'h0, ci_rx_code});
      hrd_host_inst.xfer(1'b0, 8'h88, 32'h0, q);
      check(q, 32'h1);
      do_reset();
      scan();
      conclude();
   end
endmodule : tb
